// [rtl/smc_cfg_regs.sv]
`timescale 1ns/1ps
module smc_cfg_regs (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_be,
	input wire logic [3:0] flag_set,
	input wire logic [1:0] boot_sel,
	output smc_pkg::smc_bank_cfg_t [3:0] cfg
);
	import smc_pkg::*;

	logic boot_load_q;
	logic [31:0] cfg_q [4];
	logic [31:0] be_mask;

	assign be_mask = {{8{wr_be[3]}}, {8{wr_be[2]}}, {8{wr_be[1]}},
		{8{wr_be[0]}}};

	// strap is caught on the first edge after reset release
	always_ff @(posedge ref_clk) begin
		if (reset)
			boot_load_q <= 1'b1;
		else
			boot_load_q <= 1'b0;
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_bank
			logic sel;
			logic [31:0] wmask;
			assign sel = wr_en && (wr_idx == 2'(g));
			assign wmask = sel ? (be_mask & SMC_CFG_WMASK) : 32'h0;
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					cfg_q[g] <= SMC_CFG_RESET[g]; // [RULE14]
				end else begin
					cfg_q[g] <= (cfg_q[g] & ~wmask) | (wr_data & wmask);
					// hardware set beats a same-cycle software clear
					if (flag_set[g])
						cfg_q[g][SMC_FLAG_BIT] <= 1'b1; // [RULE19]
					else if (sel && wr_be[3] && wr_data[SMC_FLAG_BIT])
						cfg_q[g][SMC_FLAG_BIT] <= 1'b0; // [RULE19]
					if (g == 0 && boot_load_q) begin
						// [RULE15]
						if (boot_sel == SMC_BOOT_8)
							cfg_q[g][29:28] <= SMC_MW_8;
						else if (boot_sel == SMC_BOOT_16)
							cfg_q[g][29:28] <= SMC_MW_16;
						else
							cfg_q[g][29:28] <= SMC_MW_32;
					end
				end
			end
			assign cfg[g] = smc_bank_cfg_t'(cfg_q[g]);
		end
	endgenerate

endmodule : smc_cfg_regs

// [rtl/smc_lane.sv]
`timescale 1ns/1ps
module smc_lane (
	input wire logic [1:0] mw,
	input wire logic [1:0] beat,
	input wire logic [3:0] be,
	input wire logic [31:0] wdata,
	input wire logic [31:0] din,
	input wire logic [31:0] asm_in,
	output logic [3:0] lanes,
	output logic [31:0] dout,
	output logic [31:0] asm_out
);
	import smc_pkg::*;

	// narrow banks always use the low lanes of the external bus
	always_comb begin
		lanes = be;
		dout = wdata;
		asm_out = din;
		case (mw)
			SMC_MW_8: begin
				lanes = {3'h0, be[beat]}; // [RULE10]
				dout = {24'h0, wdata[{beat, 3'h0} +: 8]}; // [RULE20]
				asm_out = asm_in;
				asm_out[{beat, 3'h0} +: 8] = din[7:0]; // [RULE20]
			end
			SMC_MW_16: begin
				lanes = {2'h0, be[{beat[0], 1'b0} +: 2]}; // [RULE10]
				dout = {16'h0, wdata[{beat[0], 4'h0} +: 16]}; // [RULE20]
				asm_out = asm_in;
				asm_out[{beat[0], 4'h0} +: 16] = din[15:0]; // [RULE20]
			end
			default: begin
			end
		endcase
	end

endmodule : smc_lane

// [rtl/smc_pkg.sv]
package smc_pkg;

	////////////////////////////////////////////////////////////////////////
	// address map
	localparam logic [5:0] SMC_MEM_TAG = 6'h20;
	localparam int SMC_MEM_TAG_LSB = 26;
	localparam int SMC_BANK_LSB = 24;
	localparam logic [27:0] SMC_REG_TAG = 28'hFFE0000;
	localparam int SMC_REG_TAG_LSB = 4;
	localparam logic [31:0] SMC_BANK0_CONFIG_ADDR = 32'hFFE00000;
	localparam logic [31:0] SMC_BANK1_CONFIG_ADDR = 32'hFFE00004;
	localparam logic [31:0] SMC_BANK2_CONFIG_ADDR = 32'hFFE00008;
	localparam logic [31:0] SMC_BANK3_CONFIG_ADDR = 32'hFFE0000C;

	////////////////////////////////////////////////////////////////////////
	// bank configuration word
	typedef struct packed {
		logic [1:0] at;
		logic [1:0] bank_width_select;
		logic burst_rom_select;
		logic write_protect;
		logic protect_violation_flag;
		logic bus_error;
		logic [7:0] rsv_hi;
		logic [4:0] write_wait_length;
		logic read_lane_strobe_enable;
		logic [4:0] read_wait_length;
		logic rsv_lo;
		logic [3:0] idle_cycle_count;
	} smc_bank_cfg_t;

	localparam int SMC_FLAG_BIT = 25;
	localparam logic [31:0] SMC_CFG_WMASK = 32'h3C00FFEF;
	localparam logic [31:0] SMC_CFG_RESET [4] = '{
		32'h0000FBEF, 32'h2000FBEF, 32'h1000FBEF, 32'h0000FBEF};

	localparam logic [1:0] SMC_MW_8 = 2'h0;
	localparam logic [1:0] SMC_MW_16 = 2'h1;
	localparam logic [1:0] SMC_MW_32 = 2'h2;

	// boot strap code -> bank 0 width
	localparam logic [1:0] SMC_BOOT_8 = 2'h0;
	localparam logic [1:0] SMC_BOOT_16 = 2'h1;

	////////////////////////////////////////////////////////////////////////
	// timing offsets added to the programmed fields, minus one for the
	// terminal-count style counters
	localparam logic [5:0] SMC_READ_EXTRA = 6'h02;
	localparam logic [5:0] SMC_IDLE_EXTRA = 6'h01;
	localparam logic [5:0] SMC_GAP_MAX = 6'h3F;

	////////////////////////////////////////////////////////////////////////
	// external pins
	typedef struct packed {
		logic [23:0] addr;
		logic [31:0] dout;
		logic d_oe_n;
		logic [3:0] cs_n;
		logic oe_n;
		logic we_n;
		logic [3:0] byte_lane_select_n;
	} smc_mem_out_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_TURN = 3'b001,
		S_READ = 3'b010,
		S_WSETUP = 3'b011,
		S_WSTROBE = 3'b100,
		S_WHOLD = 3'b101,
		S_DONE = 3'b110
	} smc_state_t;

	function automatic logic [1:0] smc_last_beat(input logic [1:0] mw);
		case (mw)
			SMC_MW_8: smc_last_beat = 2'h3;
			SMC_MW_16: smc_last_beat = 2'h1;
			default: smc_last_beat = 2'h0;
		endcase
	endfunction : smc_last_beat

	function automatic logic [3:0] smc_width_lanes(input logic [1:0] mw);
		case (mw)
			SMC_MW_8: smc_width_lanes = 4'h1;
			SMC_MW_16: smc_width_lanes = 4'h3;
			default: smc_width_lanes = 4'hF;
		endcase
	endfunction : smc_width_lanes

	function automatic logic [23:0] smc_beat_addr(input logic [23:0] a,
			input logic [1:0] mw, input logic [1:0] beat);
		case (mw)
			SMC_MW_8: smc_beat_addr = {a[23:2], beat};
			SMC_MW_16: smc_beat_addr = {a[23:2], beat[0], 1'b0};
			default: smc_beat_addr = {a[23:2], 2'h0};
		endcase
	endfunction : smc_beat_addr

endpackage : smc_pkg

// [rtl/smc_static_memory_controller.sv]
`timescale 1ns/1ps
// Behaviour
// [RULE1] bus slave turning transfers into accesses on four external banks
// [RULE2] address bits 25:24 pick the bank; only its chip select goes low
// [RULE3] bank 0 at 0x80000000, banks 1-3 in following 16 MB windows
// [RULE4] 24-bit external address, shared 32-bit two-way data bus
// [RULE5] output enable, write enable, lane and chip selects are active low
// [RULE6] 1 to 16 idle clocks on direction change or bank change
// [RULE7] ordinary reads last 3 to 34 clocks per bank
// [RULE8] writes last 3 to 19 clocks per bank; the code gives 3 to 34 (bits 15:11 value plus three)
// [RULE9] a protected bank gets no write cycles
// [RULE10] bank width 8, 16 or 32; only those lanes driven and sampled
// [RULE11] burst ROM banks: own timing for first and later reads
// [RULE12] page-mode reads keep strobes low while low address steps
// [RULE13] per-bank choice whether lane selects go low on reads
// [RULE14] four config registers from 0xFFE00000 with given reset values
// [RULE15] bank 0 width taken from the boot pins at reset
// [RULE16] idle field bits 3:0 gives value plus one clocks
// [RULE17] read field bits 9:5 gives value plus three clocks
// [RULE18] write: setup, value plus one strobe clocks, one hold clock
// [RULE19] write to protected bank sets flag 25; written one clears it
// [RULE20] narrow banks split a word into several beats, lanes reassembled
// [RULE21] bus held in wait until the external timing has finished
module smc_static_memory_controller (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] boot_sel,
	input wire logic [31:0] mem_read_data,
	output smc_pkg::smc_mem_out_t mem_pins
);
	import smc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// transfer state

	smc_state_t state_q;
	logic mem_hit_q;
	logic reg_hit_q;
	logic is_wr_q;
	logic [1:0] bank_q;
	logic [23:0] addr_q;
	logic [3:0] be_q;
	logic [31:0] wdata_q;
	logic [1:0] beat_q;
	logic [5:0] cnt_q;
	logic [31:0] asm_q;
	logic prev_valid_q;
	logic [1:0] prev_bank_q;
	logic prev_wr_q;
	logic [5:0] gap_q;
	logic [3:0] flag_set_q;
	logic [31:0] readdata_q;
	logic waitrequest_q;
	smc_mem_out_t pins_q;

	smc_bank_cfg_t [3:0] cfg;
	smc_bank_cfg_t cur;
	logic [3:0] lanes;
	logic [31:0] lane_dout;
	logic [31:0] asm_next;
	logic [1:0] last_beat;
	logic is_last;
	logic req;
	logic req_mem;
	logic req_reg;
	logic wr_blocked;
	logic turn_needed;
	logic turn_done;
	logic in_access;
	logic reg_wr_en;
	logic [3:0] cs_sel_n;
	logic [3:0] read_bls_n;
	logic [5:0] first_read_len;
	logic [5:0] next_read_len;

	assign cur = cfg[bank_q];
	assign last_beat = smc_last_beat(cur.bank_width_select);
	assign is_last = (beat_q == last_beat);
	assign req = avs_read || avs_write;
	assign req_mem = avs_address[31:SMC_MEM_TAG_LSB] == SMC_MEM_TAG; // [RULE3]
	assign req_reg = (avs_address[31:SMC_REG_TAG_LSB] == SMC_REG_TAG) &&
		(avs_address[1:0] == 2'h0);
	// a write into a protected bank never reaches the pins
	assign wr_blocked = req_mem && avs_write &&
		cfg[avs_address[SMC_BANK_LSB +: 2]].write_protect; // [RULE9]
	assign in_access = (state_q == S_READ) || (state_q == S_WSETUP) ||
		(state_q == S_WSTROBE) || (state_q == S_WHOLD);
	assign reg_wr_en = (state_q == S_DONE) && reg_hit_q && is_wr_q;
	assign cs_sel_n = ~(4'h1 << bank_q); // [RULE2] [RULE5]
	assign read_bls_n = cur.read_lane_strobe_enable ?
		~smc_width_lanes(cur.bank_width_select) : 4'hF; // [RULE13]

	// counters load length minus one
	assign first_read_len = {1'b0, cur.read_wait_length} +
		SMC_READ_EXTRA; // [RULE7] [RULE17]
	assign next_read_len = cur.burst_rom_select ?
		{1'b0, cur.write_wait_length} : first_read_len; // [RULE11]

	// turnaround only on a bank change or a direction change
	// the answer cycle is counted too, so the gap errs on the long side
	assign turn_needed = prev_valid_q &&
		((prev_bank_q != bank_q) || (prev_wr_q != is_wr_q)); // [RULE6]
	assign turn_done = !turn_needed ||
		(gap_q >= ({2'h0, cur.idle_cycle_count} +
		SMC_IDLE_EXTRA)); // [RULE16]

	////////////////////////////////////////////////////////////////////////
	// helpers

	smc_cfg_regs u_regs (
		.ref_clk(ref_clk),
		.reset(reset),
		.wr_en(reg_wr_en),
		.wr_idx(addr_q[3:2]),
		.wr_data(wdata_q),
		.wr_be(be_q),
		.flag_set(flag_set_q),
		.boot_sel(boot_sel),
		.cfg(cfg)
	);

	// lane steering and read assembly for narrow banks
	smc_lane u_lane (
		.mw(cur.bank_width_select),
		.beat(beat_q),
		.be(be_q),
		.wdata(wdata_q),
		.din(mem_read_data),
		.asm_in(asm_q),
		.lanes(lanes),
		.dout(lane_dout),
		.asm_out(asm_next)
	);

	////////////////////////////////////////////////////////////////////////
	// idle clocks seen on the external bus since the last access
	// saturates, so a long idle spell never wraps below the limit

	always_ff @(posedge ref_clk) begin
		if (reset)
			gap_q <= SMC_GAP_MAX;
		else if (in_access)
			gap_q <= 6'h00;
		else if (gap_q != SMC_GAP_MAX)
			gap_q <= gap_q + 6'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// request capture
	// captured once, at the take edge, for the whole transfer

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mem_hit_q <= 1'b0;
			reg_hit_q <= 1'b0;
			is_wr_q <= 1'b0;
			bank_q <= 2'h0;
			addr_q <= 24'h0;
			be_q <= 4'h0;
			wdata_q <= 32'h0;
		end else if (state_q == S_IDLE && req) begin
			mem_hit_q <= req_mem;
			reg_hit_q <= req_reg;
			is_wr_q <= avs_write;
			bank_q <= avs_address[SMC_BANK_LSB +: 2]; // [RULE2]
			addr_q <= avs_address[23:0]; // [RULE4]
			be_q <= avs_byteenable;
			wdata_q <= avs_writedata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// protect violation pulse; the config block lets it beat a same-cycle
	// clear, so a violation is never lost

	always_ff @(posedge ref_clk) begin
		if (reset)
			flag_set_q <= 4'h0;
		else if (state_q == S_IDLE && req && wr_blocked)
			flag_set_q <= 4'h1 <<
				avs_address[SMC_BANK_LSB +: 2]; // [RULE19]
		else
			flag_set_q <= 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// last access, for turnaround decisions
	// skipped write beats never touch the bus, so they leave it as is

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prev_valid_q <= 1'b0;
			prev_bank_q <= 2'h0;
			prev_wr_q <= 1'b0;
		end else if (state_q == S_TURN && turn_done &&
				!(is_wr_q && lanes == 4'h0)) begin
			prev_valid_q <= 1'b1;
			prev_bank_q <= bank_q;
			prev_wr_q <= is_wr_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= S_IDLE;
			beat_q <= 2'h0;
			cnt_q <= 6'h00;
			asm_q <= 32'h0;
			readdata_q <= 32'h0;
			waitrequest_q <= 1'b1;
			pins_q.addr <= 24'h0;
			pins_q.dout <= 32'h0;
			pins_q.d_oe_n <= 1'b1;
			pins_q.cs_n <= 4'hF;
			pins_q.oe_n <= 1'b1;
			pins_q.we_n <= 1'b1;
			pins_q.byte_lane_select_n <= 4'hF;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					beat_q <= 2'h0;
					asm_q <= 32'h0;
					if (req && req_mem) begin
						if (wr_blocked) begin
							// no external cycle at all
							waitrequest_q <= 1'b0; // [RULE9]
							state_q <= S_DONE;
						end else begin
							state_q <= S_TURN;
						end
					end else if (req) begin
						// registers answer at once, unmapped reads as zero
						readdata_q <= req_reg ?
							cfg[avs_address[3:2]] : 32'h0;
						waitrequest_q <= 1'b0;
						state_q <= S_DONE;
					end
				end
				S_TURN: begin
					if (turn_done) begin
						pins_q.addr <= smc_beat_addr(addr_q,
							cur.bank_width_select, beat_q); // [RULE20]
						if (!is_wr_q) begin
							pins_q.cs_n <= cs_sel_n;
							pins_q.oe_n <= 1'b0;
							pins_q.byte_lane_select_n <= read_bls_n;
							cnt_q <= first_read_len;
							state_q <= S_READ;
						end else if (lanes == 4'h0) begin
							// beats with no enabled byte are skipped
							if (is_last) begin
								waitrequest_q <= 1'b0;
								state_q <= S_DONE;
							end else begin
								beat_q <= beat_q + 2'h1;
							end
						end else begin
							pins_q.dout <= lane_dout;
							pins_q.d_oe_n <= 1'b0;
							state_q <= S_WSETUP; // [RULE18]
						end
					end
				end
				S_READ: begin
					if (cnt_q != 6'h00) begin
						cnt_q <= cnt_q - 6'h01;
					end else if (is_last) begin
						pins_q.cs_n <= 4'hF;
						pins_q.oe_n <= 1'b1;
						pins_q.byte_lane_select_n <= 4'hF;
						// pins sampled at the edge ending the last strobe clock
						readdata_q <= asm_next; // [RULE10]
						waitrequest_q <= 1'b0; // [RULE21]
						state_q <= S_DONE;
					end else begin
						// strobes stay low, only the low address moves
						asm_q <= asm_next;
						beat_q <= beat_q + 2'h1;
						pins_q.addr <= smc_beat_addr(addr_q,
							cur.bank_width_select,
							beat_q + 2'h1); // [RULE12] [RULE20]
						cnt_q <= next_read_len; // [RULE11]
					end
				end
				S_WSETUP: begin
					// address and data have stood a full clock before strobes
					pins_q.cs_n <= cs_sel_n;
					pins_q.we_n <= 1'b0;
					pins_q.byte_lane_select_n <= ~lanes; // [RULE10]
					cnt_q <= {1'b0, cur.write_wait_length}; // [RULE8] [RULE18]
					state_q <= S_WSTROBE;
				end
				S_WSTROBE: begin
					if (cnt_q != 6'h00) begin
						cnt_q <= cnt_q - 6'h01;
					end else begin
						pins_q.we_n <= 1'b1;
						pins_q.byte_lane_select_n <= 4'hF;
						state_q <= S_WHOLD; // [RULE18]
					end
				end
				S_WHOLD: begin
					// data is released together with chip select, never before
					pins_q.cs_n <= 4'hF;
					pins_q.d_oe_n <= 1'b1;
					if (is_last) begin
						waitrequest_q <= 1'b0; // [RULE21]
						state_q <= S_DONE;
					end else begin
						beat_q <= beat_q + 2'h1;
						state_q <= S_TURN;
					end
				end
				S_DONE: begin
					// the master samples the answer at this edge
					waitrequest_q <= 1'b1;
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign avs_readdata = readdata_q;
	assign avs_waitrequest = waitrequest_q; // [RULE1]
	assign mem_pins = pins_q;

endmodule : smc_static_memory_controller

// [testbench/smc_sram_model.sv]
`timescale 1ns/1ps
module smc_sram_model (
	input wire logic ref_clk,
	input wire smc_pkg::smc_mem_out_t mem_pins,
	output logic [31:0] mem_read_data
);
	import smc_pkg::*;
	logic [31:0] store [logic [27:0]];
	logic [31:0] last_q;
	wire logic [27:0] key = {mem_pins.cs_n, mem_pins.addr};
	always @(posedge ref_clk) begin
		last_q <= mem_read_data;
		if (mem_pins.cs_n != 4'hF && !mem_pins.we_n)
			for (int i = 0; i < 4; i++)
				if (!mem_pins.byte_lane_select_n[i])
					store[key][8 * i +: 8] = mem_pins.dout[8 * i +: 8];
	end
	// released bus toggles so a stale value is never read as good
	always @* begin
		if (!mem_pins.d_oe_n)
			mem_read_data = mem_pins.dout;
		else if (mem_pins.cs_n != 4'hF && !mem_pins.oe_n)
			mem_read_data = store.exists(key) ? store[key] : 32'h0;
		else
			mem_read_data = ~last_q;
	end
endmodule : smc_sram_model

// [testbench/smc_static_memory_controller_properties.sv]
`timescale 1ns/1ps
module smc_static_memory_controller_properties (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire smc_pkg::smc_mem_out_t mem_pins
);
	import smc_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	sequence s_read_run;
		(!mem_pins.oe_n && mem_pins.cs_n != 4'hF) [*3];
	endsequence
	sequence s_write_hold;
		(mem_pins.cs_n != 4'hF && &mem_pins.byte_lane_select_n) ##1
			&mem_pins.cs_n;
	endsequence
	a_cs_bank: assert property (
		mem_pins.cs_n != 4'hF |->
			mem_pins.cs_n == (4'hF ^ (4'h1 << avs_address[25:24])))
		else $error("chip select does not match bank");
	a_strobe_excl: assert property (
		!(!mem_pins.oe_n && !mem_pins.we_n))
		else $error("read and write strobes low together");
	a_write_drive: assert property (
		!mem_pins.we_n |-> !mem_pins.d_oe_n && mem_pins.cs_n != 4'hF)
		else $error("write strobe without data drive");
	a_write_setup: assert property (
		$fell(mem_pins.we_n) |-> $past(mem_pins.cs_n) == 4'hF &&
			!$past(mem_pins.d_oe_n))
		else $error("write strobe without setup cycle");
	a_write_hold: assert property (
		$rose(mem_pins.we_n) |-> s_write_hold)
		else $error("write hold cycle wrong");
	a_read_min: assert property (
		$fell(mem_pins.oe_n) |-> s_read_run)
		else $error("read shorter than three clocks");
	a_wait_single: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	a_reg_answer: assert property (
		$rose(avs_read || avs_write) && avs_address[31:4] == SMC_REG_TAG
			|=> !avs_waitrequest)
		else $error("register access not answered in one cycle");
	a_mem_answer: assert property (
		!avs_waitrequest && avs_read && avs_address[31:26] == SMC_MEM_TAG
			|-> !$past(mem_pins.oe_n))
		else $error("read answered before external read");
	a_idle_gap: assert property (
		$rose(&mem_pins.cs_n) |=> &mem_pins.cs_n)
		else $error("no idle clock after access");
endmodule : smc_static_memory_controller_properties

bind smc_static_memory_controller smc_static_memory_controller_properties
	u_props (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .mem_pins(mem_pins));

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
	import smc_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] avs_address = 32'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [1:0] boot_sel = 2'h1;
	logic [31:0] avs_readdata, mem_read_data, lfsr_q = 32'hD461;
	logic avs_waitrequest;
	smc_mem_out_t mem_pins;
	int failures = 0, checks = 0;
	int oe_run = 0, oe_len = 0, we_run = 0, we_len = 0, we_cnt = 0;
	int idle_run = 0, gap = 0, gap_first = 0;
	logic gap_arm = 1'b0;
	logic [23:0] rd_addr;
	logic [3:0] rd_bls, rd_cs;
	logic [31:0] ref_mem [logic [31:0]];
	logic [31:0] last_a [4];
	localparam logic [31:0] RST_T [4] = '{32'h1000FBEF, 32'h2000FBEF,
		32'h1000FBEF, 32'h0000FBEF};
	localparam logic [31:0] CFG_T [4] = '{32'h10000C40, 32'h20000C40,
		32'h00000845, 32'h24000C40};
	localparam int BEATS_T [4] = '{2, 1, 4, 1};
	localparam int GAP_T [4] = '{1, 1, 6, 1};
	localparam logic [3:0] BLS_T [4] = '{4'hC, 4'h0, 4'hF, 4'h0};

	always #5 ref_clk = ~ref_clk;

	smc_static_memory_controller dut (.ref_clk(ref_clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .boot_sel(boot_sel),
		.mem_read_data(mem_read_data), .mem_pins(mem_pins));
	smc_sram_model u_mem (.ref_clk(ref_clk), .mem_pins(mem_pins),
		.mem_read_data(mem_read_data));

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		if (!mem_pins.oe_n) begin
			if (oe_run == 0) begin
				rd_addr = mem_pins.addr;
				rd_bls = mem_pins.byte_lane_select_n;
				rd_cs = mem_pins.cs_n;
			end
			oe_run++;
		end else if (oe_run != 0) begin
			oe_len = oe_run;
			oe_run = 0;
		end
		if (!mem_pins.we_n)
			we_run++;
		else if (we_run != 0) begin
			we_len = we_run;
			we_cnt++;
			we_run = 0;
		end
		if (&mem_pins.cs_n)
			idle_run++;
		else if (idle_run != 0) begin
			gap = idle_run;
			if (gap_arm)
				gap_first = idle_run;
			gap_arm = 1'b0;
			idle_run = 0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// one request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [31:0] a, d,
			input logic [3:0] be, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		do
			@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic mem_test(input int b, input logic bm);
		logic [31:0] a, q;
		int wc;
		a = last_a[b];
		if (!bm) begin
			lfsr_q = lfsr(lfsr_q);
			a = 32'h80000000 | (32'(b) << 24) | (lfsr_q & 32'h00FFFFFC);
			wc = we_cnt;
			gap_arm = 1'b1;
			bus(1'b1, a, lfsr_q, 4'hF, q);
			ref_mem[a] = lfsr_q;
			#1;
			check(we_cnt - wc, BEATS_T[b]);
			check(we_len, 2);
			check(gap_first >= GAP_T[b], 1);
			lfsr_q = lfsr(lfsr_q);
			bus(1'b1, a, lfsr_q, lfsr_q[11:8], q);
			for (int i = 0; i < 4; i++)
				if (lfsr_q[8 + i])
					ref_mem[a][8 * i +: 8] = lfsr_q[8 * i +: 8];
		end
		last_a[b] = a;
		bus(1'b0, a, 32'h0, 4'hF, q);
		#1;
		check(q, ref_mem[a]);
		check(rd_cs, 4'hF ^ (4'h1 << b));
		check(rd_addr, a & 32'h00FFFFFC);
		check(rd_bls, BLS_T[b]);
		check(oe_len, (bm ? 2 : 5) * (BEATS_T[b] - 1) + 5);
		check(gap >= GAP_T[b], 1);
	endtask : mem_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		int wc;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, SMC_BANK0_CONFIG_ADDR + 4 * i, 32'h0, 4'hF, q);
			check(q, RST_T[i]);
		end
		bus(1'b0, 32'hFFE00010, 32'h0, 4'hF, q);
		check(q, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, SMC_BANK0_CONFIG_ADDR + 4 * i, CFG_T[i] | 32'hC0FF0010,
				4'hF, q);
			bus(1'b0, SMC_BANK0_CONFIG_ADDR + 4 * i, 32'h0, 4'hF, q);
			check(q, CFG_T[i] & SMC_CFG_WMASK);
		end
		for (int r = 0; r < 12; r++)
			mem_test(r % 3, 1'b0);
		wc = we_cnt;
		bus(1'b1, 32'h83000010, 32'h12345678, 4'hF, q);
		#1;
		check(we_cnt - wc, 0);
		bus(1'b0, SMC_BANK3_CONFIG_ADDR, 32'h0, 4'hF, q);
		check(q, (CFG_T[3] & SMC_CFG_WMASK) | 32'h02000000);
		bus(1'b1, SMC_BANK3_CONFIG_ADDR, CFG_T[3] | 32'h02000000, 4'hF, q);
		bus(1'b0, SMC_BANK3_CONFIG_ADDR, 32'h0, 4'hF, q);
		check(q, CFG_T[3] & SMC_CFG_WMASK);
		bus(1'b1, SMC_BANK0_CONFIG_ADDR, CFG_T[0] | 32'h08000000, 4'hF, q);
		mem_test(0, 1'b1);
		// second reset with the strap asking for a 32-bit boot bank
		@(posedge ref_clk);
		boot_sel <= 2'h2;
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		bus(1'b0, SMC_BANK0_CONFIG_ADDR, 32'h0, 4'hF, q);
		check(q, 32'h2000FBEF);
		bus(1'b0, SMC_BANK3_CONFIG_ADDR, 32'h0, 4'hF, q);
		check(q, 32'h0000FBEF);
		conclude();
	end

	initial begin
		#500000;
		failures++;
		conclude();
	end
endmodule : tb
